// File: verilog/trig_qual_pkg.sv
// Purpose: Shared constants and types for the trace trigger qualifier
// Assumes: One 10 MHz clock; bus strobes arrive asynchronously on pins
// Notes: Cycle type and data mode codes are the encodings of the config ports
package trig_qual_pkg;
	// Widths of the monitored bus and the number of qualifier lines
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int LINES = 4;
	localparam int TRACE_W = 8;
	// Cycle type selections per qualifier line
	localparam logic [1:0] CYC_INCLUDE_ALL = 2'h0;
	localparam logic [1:0] CYC_FETCH_OR_READ = 2'h1;
	localparam logic [1:0] CYC_DATA_OR_WRITE = 2'h2;
	localparam logic [1:0] CYC_EXCLUDE_ALL = 2'h3;
	// Data compare modes
	localparam logic DMODE_RANGE = 1'b0;
	localparam logic DMODE_PATTERN = 1'b1;
	// Values after reset
	localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h00_0000;
	localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
	localparam logic [TRACE_W-1:0] TRACE_RESET = 8'h00;
	// Synchroniser depth in cycles
	localparam int SYNC_STAGES = 2;
	// Bus cycle phases
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_ADDR,
		PH_DATA
	} phase_e;
endpackage : trig_qual_pkg

// File: verilog/line_match.sv
// Purpose: One address qualifier line: cycle type and inclusive range test
// Assumes: Inputs already stable and on the system clock
// Notes: Purely combinational; the caller registers the result
`timescale 1ns/1ps
module line_match #(
	parameter int ADDR_W = 24
) (
	// Cycle description
	input wire logic data_mode_i,
	input wire logic fetch_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [ADDR_W-1:0] mask_i,
	// Line programming
	input wire logic [1:0] cyc_type_i,
	input wire logic [ADDR_W-1:0] begin_i,
	input wire logic [ADDR_W-1:0] end_i,
	// Result
	output logic hit_o
);
	wire logic [ADDR_W-1:0] a_eff;
	wire logic [ADDR_W-1:0] b_eff;
	wire logic [ADDR_W-1:0] e_eff;
	wire logic in_range;
	wire logic data_acc;
	logic type_ok;

	// Mask both the cycle address and the bounds
	assign a_eff = addr_i & mask_i; // [R13]
	assign b_eff = begin_i & mask_i; // [R13]
	assign e_eff = end_i & mask_i; // [R13]
	assign in_range = (a_eff >= b_eff) && (a_eff <= e_eff); // [R5]
	assign data_acc = read_i | write_i;

	// Cycle type selection; fetch is never seen in data mode
	always_comb begin
		case (cyc_type_i)
			trig_qual_pkg::CYC_INCLUDE_ALL: type_ok = data_mode_i ? data_acc : (fetch_i | data_acc); // [R1] [R6]
			trig_qual_pkg::CYC_FETCH_OR_READ: type_ok = data_mode_i ? read_i : fetch_i; // [R2] [R7]
			trig_qual_pkg::CYC_DATA_OR_WRITE: type_ok = data_mode_i ? write_i : data_acc; // [R3] [R8]
			default: type_ok = 1'b0; // [R4]
		endcase
	end

	assign hit_o = type_ok & in_range;
endmodule : line_match

// File: verilog/trace_trigger_qualifier.sv
// Purpose: Trigger qualifier for the trace board watching external bus cycles
// Assumes: Strobes and bus pins are asynchronous; all pass two flip-flops
// Notes: Bus must hold address/data a few clocks around each strobe edge
`timescale 1ns/1ps
// Operation
// R1: Opcode mode include-all: fetch or data access
// R2: Opcode mode fetch-only: instruction fetches only
// R3: Opcode mode data: any read or write
// R4: Exclude-all line never matches
// R5: Address range inclusive at both ends
// R6: Data mode include-all: any read or write
// R7: Data mode read-only: reads only
// R8: Data mode write-only: writes only
// R9: Address and data qualify same cycle
// R10: Data range inclusive, end counted inside
// R11: Data pattern equality on bits
// R12: Data spec ANDed with data mask
// R13: Address spec ANDed with address mask
// R14: Disabled trigger produces no match
// R15: Inputs 0-3 sampled at ALE fall
// R16: Inputs 4-7 sampled at strobe rise
// R17: Lines ORed, address AND data results
// R18: Evaluate once per cycle on latched values
module trace_trigger_qualifier #(
	parameter int ADDR_W = trig_qual_pkg::ADDR_W,
	parameter int DATA_W = trig_qual_pkg::DATA_W,
	parameter int LINES = trig_qual_pkg::LINES
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// Monitored bus pins
	input wire logic addr_strobe_i,
	input wire logic read_strobe_n_i,
	input wire logic write_strobe_n_i,
	input wire logic fetch_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] data_i,
	input wire logic [trig_qual_pkg::TRACE_W-1:0] trace_pins_i,
	// Trigger configuration
	input wire logic enable_i,
	input wire logic data_mode_i,
	input wire logic [2*LINES-1:0] cyc_type_i,
	input wire logic [LINES*ADDR_W-1:0] addr_begin_i,
	input wire logic [LINES*ADDR_W-1:0] addr_end_i,
	input wire logic [ADDR_W-1:0] addr_mask_i,
	input wire logic [LINES-1:0] data_line_en_i,
	input wire logic [LINES-1:0] data_cmp_mode_i,
	input wire logic [LINES*DATA_W-1:0] data_begin_i,
	input wire logic [LINES*DATA_W-1:0] data_end_i,
	input wire logic [DATA_W-1:0] data_mask_i,
	// Results
	output logic trigger_o,
	output logic cycle_done_o,
	output logic [ADDR_W-1:0] rec_addr_o,
	output logic [DATA_W-1:0] rec_data_o,
	output logic rec_write_o,
	output logic [trig_qual_pkg::TRACE_W-1:0] rec_trace_o
);
	// Synchroniser stages; the second stage is read by logic, and the strobes' third stage by edge detection
	logic ale_s1_q, ale_s2_q, ale_s3_q;
	logic rd_s1_q, rd_s2_q, rd_s3_q;
	logic wr_s1_q, wr_s2_q, wr_s3_q;
	logic fetch_s1_q, fetch_s2_q;
	logic [ADDR_W-1:0] addr_s1_q, addr_s2_q;
	logic [DATA_W-1:0] data_s1_q, data_s2_q;
	logic [trig_qual_pkg::TRACE_W-1:0] trc_s1_q, trc_s2_q;

	// Latched cycle state
	trig_qual_pkg::phase_e phase_q, phase_d;
	logic [ADDR_W-1:0] addr_q;
	logic fetch_q;
	logic [trig_qual_pkg::TRACE_W-1:0] trace_q;
	logic trigger_q, done_q, rec_wr_q;
	logic [DATA_W-1:0] rec_data_q;

	// Edge detection on synchronised strobes
	wire logic ale_fall;
	wire logic rd_rise;
	wire logic wr_rise;
	wire logic strobe_rise;
	assign ale_fall = ale_s3_q & ~ale_s2_q;
	assign rd_rise = rd_s2_q & ~rd_s3_q;
	assign wr_rise = wr_s2_q & ~wr_s3_q;
	assign strobe_rise = rd_rise | wr_rise;

	// Two flip-flops on every pin so metastability never reaches decode
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			{ale_s1_q, ale_s2_q, ale_s3_q} <= 3'h0;
			{rd_s1_q, rd_s2_q, rd_s3_q} <= 3'h7;
			{wr_s1_q, wr_s2_q, wr_s3_q} <= 3'h7;
			{fetch_s1_q, fetch_s2_q} <= 2'h0;
			addr_s1_q <= trig_qual_pkg::ADDR_RESET;
			addr_s2_q <= trig_qual_pkg::ADDR_RESET;
			data_s1_q <= trig_qual_pkg::DATA_RESET;
			data_s2_q <= trig_qual_pkg::DATA_RESET;
			trc_s1_q <= trig_qual_pkg::TRACE_RESET;
			trc_s2_q <= trig_qual_pkg::TRACE_RESET;
		end else begin
			{ale_s1_q, ale_s2_q, ale_s3_q} <= {addr_strobe_i, ale_s1_q, ale_s2_q};
			{rd_s1_q, rd_s2_q, rd_s3_q} <= {read_strobe_n_i, rd_s1_q, rd_s2_q};
			{wr_s1_q, wr_s2_q, wr_s3_q} <= {write_strobe_n_i, wr_s1_q, wr_s2_q};
			{fetch_s1_q, fetch_s2_q} <= {fetch_i, fetch_s1_q};
			addr_s1_q <= addr_i;
			addr_s2_q <= addr_s1_q;
			data_s1_q <= data_i;
			data_s2_q <= data_s1_q;
			trc_s1_q <= trace_pins_i;
			trc_s2_q <= trc_s1_q;
		end
	end

	// Cycle phase: address latched, then waiting for the data strobe
	// A new address strobe always restarts the cycle, so a lost strobe cannot wedge it
	always_comb begin
		phase_d = phase_q;
		case (phase_q)
			trig_qual_pkg::PH_IDLE: if (ale_fall) phase_d = trig_qual_pkg::PH_ADDR;
			trig_qual_pkg::PH_ADDR: phase_d = trig_qual_pkg::PH_DATA;
			trig_qual_pkg::PH_DATA: if (strobe_rise) phase_d = trig_qual_pkg::PH_IDLE; // [R18]
			default: phase_d = trig_qual_pkg::PH_IDLE;
		endcase
		if (ale_fall) phase_d = trig_qual_pkg::PH_ADDR;
	end

	// Cycle kind of the strobe now ending; a fetch is a read with fetch flag
	wire logic cyc_read;
	wire logic cyc_write;
	wire logic cyc_fetch;
	wire logic evaluate;
	assign evaluate = (phase_q == trig_qual_pkg::PH_DATA) && strobe_rise; // [R18]
	assign cyc_fetch = rd_rise & fetch_q;
	assign cyc_read = rd_rise & ~fetch_q;
	assign cyc_write = wr_rise;

	// Masked data compare, shared by all data lines
	function automatic logic data_hit(input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] lo,
		input logic [DATA_W-1:0] hi, input logic [DATA_W-1:0] m, input logic pat);
		logic [DATA_W-1:0] de;
		de = d & m; // [R12]
		if (pat == trig_qual_pkg::DMODE_PATTERN)
			data_hit = (de == (lo & m)); // [R11]
		else
			data_hit = (de >= (lo & m)) && (de <= (hi & m)); // [R10]
	endfunction : data_hit

	// Address and data lines
	wire logic [LINES-1:0] addr_hits;
	wire logic [LINES-1:0] data_hits;
	genvar g;
	generate
		for (g = 0; g < LINES; g++) begin : g_line
			line_match #(.ADDR_W(ADDR_W)) u_line (
				.data_mode_i(data_mode_i),
				.fetch_i(cyc_fetch),
				.read_i(cyc_read),
				.write_i(cyc_write),
				.addr_i(addr_q),
				.mask_i(addr_mask_i),
				.cyc_type_i(cyc_type_i[2*g +: 2]),
				.begin_i(addr_begin_i[g*ADDR_W +: ADDR_W]),
				.end_i(addr_end_i[g*ADDR_W +: ADDR_W]),
				.hit_o(addr_hits[g])
			);
			assign data_hits[g] = data_line_en_i[g] & data_hit(data_s2_q, data_begin_i[g*DATA_W +: DATA_W],
				data_end_i[g*DATA_W +: DATA_W], data_mask_i, data_cmp_mode_i[g]);
		end
	endgenerate

	// OR within each window, then AND; an empty data window passes
	wire logic addr_ok;
	wire logic data_ok;
	wire logic match;
	assign addr_ok = |addr_hits; // [R17]
	assign data_ok = (data_line_en_i == '0) ? 1'b1 : (|data_hits); // [R17] [R9]
	assign match = enable_i & evaluate & addr_ok & data_ok; // [R14] [R9]

	// Latch address and low trace bits at address strobe fall
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			phase_q <= trig_qual_pkg::PH_IDLE;
			addr_q <= trig_qual_pkg::ADDR_RESET;
			fetch_q <= 1'b0;
			trace_q <= trig_qual_pkg::TRACE_RESET;
		end else begin
			phase_q <= phase_d;
			if (ale_fall) begin
				addr_q <= addr_s2_q; // [R18]
				fetch_q <= fetch_s2_q;
				trace_q[3:0] <= trc_s2_q[3:0]; // [R15]
			end
			if (strobe_rise) trace_q[7:4] <= trc_s2_q[7:4]; // [R16]
		end
	end

	// Result outputs, one done pulse per evaluated cycle and one trigger pulse per qualified cycle
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			trigger_q <= 1'b0;
			done_q <= 1'b0;
			rec_wr_q <= 1'b0;
			rec_data_q <= trig_qual_pkg::DATA_RESET;
		end else begin
			trigger_q <= match;
			done_q <= evaluate;
			if (evaluate) begin
				rec_wr_q <= cyc_write;
				rec_data_q <= data_s2_q; // [R18]
			end
		end
	end

	// Record trace bits: high nibble from the strobe just seen
	logic [trig_qual_pkg::TRACE_W-1:0] rec_trace_q;
	logic [ADDR_W-1:0] rec_addr_q;
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			rec_trace_q <= trig_qual_pkg::TRACE_RESET;
			rec_addr_q <= trig_qual_pkg::ADDR_RESET;
		end else if (evaluate) begin
			rec_trace_q <= {trc_s2_q[7:4], trace_q[3:0]}; // [R15] [R16]
			rec_addr_q <= addr_q;
		end
	end

	assign trigger_o = trigger_q;
	assign cycle_done_o = done_q;
	assign rec_addr_o = rec_addr_q;
	assign rec_data_o = rec_data_q;
	assign rec_write_o = rec_wr_q;
	assign rec_trace_o = rec_trace_q;
endmodule : trace_trigger_qualifier

// File: testbench/trig_qual_checker.sv
// Purpose: Port-level assertions for the trace trigger qualifier
// Assumes: Bus pins held around strobe edges as the bus model does
// Notes: Config is sampled one cycle before the result pulse
`timescale 1ns/1ps
module trig_qual_checker #(
	parameter int ADDR_W = 24,
	parameter int DATA_W = 16,
	parameter int LINES = 4
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// Watched inputs
	input wire logic addr_strobe_i,
	input wire logic read_strobe_n_i,
	input wire logic write_strobe_n_i,
	input wire logic [DATA_W-1:0] data_i,
	input wire logic [7:0] trace_pins_i,
	input wire logic enable_i,
	input wire logic [2*LINES-1:0] cyc_type_i,
	// Watched outputs
	input wire logic trigger_o,
	input wire logic cycle_done_o,
	input wire logic [ADDR_W-1:0] rec_addr_o,
	input wire logic [DATA_W-1:0] rec_data_o,
	input wire logic [7:0] rec_trace_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	// Strobe already back high and address strobe low two clocks before the result
	sequence s_bus_settled;
		$past(read_strobe_n_i && write_strobe_n_i, 2) && !$past(addr_strobe_i, 2);
	endsequence
	a_trig_with_done: assert property (trigger_o |-> cycle_done_o) else $error("trigger without cycle end");
	a_done_one_cycle: assert property (cycle_done_o |=> !cycle_done_o) else $error("cycle end pulse too long");
	a_done_after_strobe: assert property (cycle_done_o |-> s_bus_settled) else $error("cycle end before strobe rise");
	a_trig_disabled: assert property (!$past(enable_i) |-> !trigger_o) else $error("trigger while disabled");
	a_blank_window: assert property (&$past(cyc_type_i) |-> !trigger_o) else $error("trigger from excluded lines");
	a_rec_holds: assert property (!cycle_done_o |-> $stable(rec_addr_o) && $stable(rec_data_o)) else $error("record moved");
	a_data_rec: assert property (cycle_done_o |-> rec_data_o == $past(data_i, 3)) else $error("record data wrong");
	a_trace_high: assert property (cycle_done_o |-> rec_trace_o[7:4] == $past(trace_pins_i[7:4], 3))
		else $error("upper trace bits wrong");
endmodule : trig_qual_checker
bind trace_trigger_qualifier trig_qual_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .LINES(LINES)) checker_i (
	.clock_i(clock_i), .reset_i(reset_i), .addr_strobe_i(addr_strobe_i), .read_strobe_n_i(read_strobe_n_i),
	.write_strobe_n_i(write_strobe_n_i), .data_i(data_i), .trace_pins_i(trace_pins_i), .enable_i(enable_i),
	.cyc_type_i(cyc_type_i), .trigger_o(trigger_o), .cycle_done_o(cycle_done_o), .rec_addr_o(rec_addr_o),
	.rec_data_o(rec_data_o), .rec_trace_o(rec_trace_o));

// File: testbench/bus_model.sv
// Purpose: Emulated controller issuing fetch, read and write bus cycles
// Assumes: Each edge held four or more clocks, as the qualifier needs
// Notes: Released pins show inverted values so stale data cannot match
`timescale 1ns/1ps
module bus_model (
	// Clock
	input wire logic clock_i,
	// Bus pins
	output logic ale_o = 1'b0,
	output logic rd_n_o = 1'b1,
	output logic wr_n_o = 1'b1,
	output logic fetch_o = 1'b0,
	output logic [23:0] addr_o = 24'h00_0000,
	output logic [15:0] data_o = 16'h0000,
	output logic [7:0] trace_o = 8'h00
);
	// One cycle: k 0 fetch, 1 read, 2 write; lower trace with address, upper with data
	task cycle(input logic [1:0] k, input logic [23:0] a, input logic [15:0] d, input logic [7:0] t);
		@(posedge clock_i);
		ale_o <= 1'b1;
		addr_o <= a;
		fetch_o <= (k == 2'h0);
		trace_o[3:0] <= t[3:0];
		repeat (4) @(posedge clock_i);
		ale_o <= 1'b0;
		repeat (4) @(posedge clock_i);
		trace_o <= {t[7:4], ~t[3:0]};
		fetch_o <= 1'b0;
		data_o <= d;
		if (k == 2'h2) wr_n_o <= 1'b0;
		else rd_n_o <= 1'b0;
		repeat (4) @(posedge clock_i);
		rd_n_o <= 1'b1;
		wr_n_o <= 1'b1;
		// Hold past the strobe rise, then release with inverted values
		repeat (6) @(posedge clock_i);
		addr_o <= ~a;
		data_o <= ~d;
		trace_o <= ~t;
	endtask : cycle
endmodule : bus_model

// File: testbench/tb_top.sv
// Purpose: Self-checking bench for the trace trigger qualifier
// Assumes: Line 0 carries the address and data tests, line 1 an address range in the mask test, others excluded
// Notes: Trace value of each cycle is derived from its address and data
`timescale 1ns/1ps
module tb_top;
	logic clock_i = 0, reset_i = 1, enable_i = 1, data_mode_i = 0, trigger_o, cycle_done_o, rec_write_o, got_trig;
	logic ale, rd_n, wr_n, fetch;
	logic [7:0] cyc_type_i = 8'hff, trace, rec_trace_o;
	logic [95:0] addr_begin_i = 96'h0, addr_end_i = 96'h0;
	logic [23:0] addr_mask_i = 24'hff_ffff, addr, rec_addr_o;
	logic [3:0] data_line_en_i = 4'h0, data_cmp_mode_i = 4'h0;
	logic [63:0] data_begin_i = 64'h0, data_end_i = 64'h0;
	logic [15:0] data_mask_i = 16'hffff, data, rec_data_o;
	int n_errors = 0, num_checks = 0, ndone = 0, ticks = 0;
	always #50 clock_i = ~clock_i;
	bus_model bus_i (.clock_i(clock_i), .ale_o(ale), .rd_n_o(rd_n), .wr_n_o(wr_n), .fetch_o(fetch),
		.addr_o(addr), .data_o(data), .trace_o(trace));
	trace_trigger_qualifier trace_trigger_qualifier_i (.clock_i(clock_i), .reset_i(reset_i), .addr_strobe_i(ale),
		.read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n), .fetch_i(fetch), .addr_i(addr), .data_i(data),
		.trace_pins_i(trace), .enable_i(enable_i), .data_mode_i(data_mode_i), .cyc_type_i(cyc_type_i),
		.addr_begin_i(addr_begin_i), .addr_end_i(addr_end_i), .addr_mask_i(addr_mask_i),
		.data_line_en_i(data_line_en_i), .data_cmp_mode_i(data_cmp_mode_i), .data_begin_i(data_begin_i),
		.data_end_i(data_end_i), .data_mask_i(data_mask_i), .trigger_o(trigger_o), .cycle_done_o(cycle_done_o),
		.rec_addr_o(rec_addr_o), .rec_data_o(rec_data_o), .rec_write_o(rec_write_o), .rec_trace_o(rec_trace_o));
	// Catch the one-cycle result pulse; cut a hang short
	always @(posedge clock_i) begin
		ticks++;
		if (cycle_done_o === 1'b1) begin
			ndone++;
			got_trig = trigger_o;
		end
		if (ticks == 5000) begin
			n_errors++;
			$display("Error at %0t: run did not finish in time", $time);
			summarize();
		end
	end
	task summarize();
		if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : summarize
	task chk(input logic c);
		num_checks++;
		if (c !== 1'b1) begin
			n_errors++;
			$display("Error at %0t: bus cycle result mismatch", $time);
		end
	endtask : chk
	// One bus cycle, then compare trigger and record
	task run(input logic [1:0] k, input logic [23:0] a, input logic [15:0] d, input logic e);
		int n0;
		n0 = ndone;
		bus_i.cycle(k, a, d, a[7:0] ^ d[7:0]);
		chk(ndone == n0 + 1 && got_trig === e && rec_addr_o === a && rec_write_o === (k == 2'h2));
		chk(rec_trace_o === (a[7:0] ^ d[7:0]) && rec_data_o === d);
	endtask : run
	task cfg(input logic m, input logic [1:0] ty, input logic [3:0] den, input logic [3:0] dcm);
		@(posedge clock_i);
		data_mode_i <= m;
		cyc_type_i <= {6'h3f, ty};
		data_line_en_i <= den;
		data_cmp_mode_i <= dcm;
	endtask : cfg
	task t_opcode();
		cfg(1'b0, trig_qual_pkg::CYC_INCLUDE_ALL, 4'h0, 4'h0);
		run(2'h0, 24'h00_0100, 16'h0011, 1'b1);
		run(2'h2, 24'h00_0110, 16'h0022, 1'b1);
		run(2'h1, 24'h00_0111, 16'h0033, 1'b0);
		cfg(1'b0, trig_qual_pkg::CYC_FETCH_OR_READ, 4'h0, 4'h0);
		run(2'h0, 24'h00_0105, 16'h0044, 1'b1);
		run(2'h1, 24'h00_0105, 16'h0055, 1'b0);
		cfg(1'b0, trig_qual_pkg::CYC_DATA_OR_WRITE, 4'h0, 4'h0);
		run(2'h1, 24'h00_0105, 16'h0066, 1'b1);
		run(2'h2, 24'h00_0105, 16'h0077, 1'b1);
		run(2'h0, 24'h00_0105, 16'h0088, 1'b0);
		cfg(1'b0, trig_qual_pkg::CYC_EXCLUDE_ALL, 4'h0, 4'h0);
		run(2'h0, 24'h00_0105, 16'h0099, 1'b0);
	endtask : t_opcode
	task t_datamode();
		cfg(1'b1, trig_qual_pkg::CYC_INCLUDE_ALL, 4'h0, 4'h0);
		run(2'h1, 24'h00_0101, 16'h0012, 1'b1);
		run(2'h2, 24'h00_0101, 16'h0013, 1'b1);
		run(2'h0, 24'h00_0101, 16'h0018, 1'b0);
		cfg(1'b1, trig_qual_pkg::CYC_FETCH_OR_READ, 4'h0, 4'h0);
		run(2'h1, 24'h00_0101, 16'h0014, 1'b1);
		run(2'h2, 24'h00_0101, 16'h0015, 1'b0);
		cfg(1'b1, trig_qual_pkg::CYC_DATA_OR_WRITE, 4'h0, 4'h0);
		run(2'h2, 24'h00_0101, 16'h0016, 1'b1);
		run(2'h1, 24'h00_0101, 16'h0017, 1'b0);
	endtask : t_datamode
	task t_data();
		cfg(1'b0, trig_qual_pkg::CYC_INCLUDE_ALL, 4'h1, 4'h0);
		data_begin_i[15:0] <= 16'h0010;
		data_end_i[15:0] <= 16'h001f;
		run(2'h1, 24'h00_0105, 16'h001f, 1'b1);
		run(2'h1, 24'h00_0105, 16'h0020, 1'b0);
		run(2'h1, 24'h00_0105, 16'h0010, 1'b1);
		run(2'h1, 24'h00_0200, 16'h0015, 1'b0);
		cfg(1'b0, trig_qual_pkg::CYC_INCLUDE_ALL, 4'h1, 4'h1);
		data_begin_i[15:0] <= 16'h007f;
		run(2'h1, 24'h00_0105, 16'h007f, 1'b1);
		run(2'h1, 24'h00_0105, 16'h007e, 1'b0);
		data_mask_i <= 16'h00f0;
		run(2'h1, 24'h00_0105, 16'h0070, 1'b1);
	endtask : t_data
	task t_mask_enable();
		cfg(1'b0, trig_qual_pkg::CYC_INCLUDE_ALL, 4'h0, 4'h0);
		@(posedge clock_i);
		cyc_type_i <= 8'hf0;
		addr_begin_i[47:24] <= 24'h00_0200;
		addr_end_i[47:24] <= 24'h00_0210;
		run(2'h1, 24'h00_0205, 16'h0021, 1'b1);
		addr_mask_i <= 24'h00_ffff;
		run(2'h1, 24'hab_0105, 16'h0023, 1'b1);
		enable_i <= 1'b0;
		run(2'h1, 24'h00_0105, 16'h0024, 1'b0);
	endtask : t_mask_enable
	// Main sequence
	initial begin
		addr_begin_i[23:0] = 24'h00_0100;
		addr_end_i[23:0] = 24'h00_0110;
		repeat (20) @(posedge clock_i);
		reset_i <= 1'b0;
		t_opcode();
		t_datamode();
		t_data();
		t_mask_enable();
		summarize();
	end
endmodule : tb_top
